/* rtl/bss_defs.svh */
// bit positions, offsets and reset values of the secondary status block
// assumes inclusion by bare name from the design file
`ifndef BSS_DEFS_SVH
`define BSS_DEFS_SVH
`define BSS_OFF_STATUS 12'h01C
`define BSS_OFF_CTRL 12'h040
`define BSS_OFF_EVT 12'h044
`define BSS_BIT_66MHZ 21
`define BSS_BIT_FBB 23
`define BSS_BIT_MDPE 24
`define BSS_LSB_SELT 25
`define BSS_BIT_STA 27
`define BSS_BIT_RTA 28
`define BSS_BIT_RMA 29
`define BSS_BIT_RSE 30
`define BSS_BIT_DPE 31
`define BSS_SELT_FWD 2'h1
`define BSS_SELT_REV 2'h0
`define BSS_RESP_OKAY 2'h0
`define BSS_RESP_SLVERR 2'h2
`define BSS_CTRL_REVERSE 0
`define BSS_CTRL_PCIX 1
`define BSS_CTRL_PERR_EN 2
`define BSS_FLAG_LSB 16
`define BSS_IDX_MDPE (`BSS_BIT_MDPE - `BSS_FLAG_LSB)
`define BSS_IDX_STA (`BSS_BIT_STA - `BSS_FLAG_LSB)
`define BSS_IDX_RTA (`BSS_BIT_RTA - `BSS_FLAG_LSB)
`define BSS_IDX_RMA (`BSS_BIT_RMA - `BSS_FLAG_LSB)
`define BSS_IDX_RSE (`BSS_BIT_RSE - `BSS_FLAG_LSB)
`define BSS_IDX_DPE (`BSS_BIT_DPE - `BSS_FLAG_LSB)
`define BSS_W1C_MASK 16'hF900
`define BSS_PIN_IDLE 3'h7
`endif

/* rtl/bss_pkg.sv */
// types shared by the secondary status block
// no assumptions beyond a SystemVerilog compiler
package bss_pkg;
    typedef enum logic [1:0] {
        BSS_IDLE = 2'b01,
        BSS_RESP = 2'b10
    } bss_bus_state_t;
endpackage : bss_pkg

/* rtl/bss_secondary_status.sv */
// secondary bus status logic of a reversible bridge, axi4-lite slave
// assumes event inputs are one-cycle pulses synchronous to aclk;
// the parity error and system error pins arrive asynchronously
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "bss_defs.svh"

// Summary of operation
// RULE1 - bit 21 reads one always
// RULE2 - forward: bit 23 one in pci mode
// RULE3 - reverse: bit 23 reads zero
// RULE4 - forward read parity error sets bit 24
// RULE5 - forward perr pin on write sets 24
// RULE6 - forward split message parity error sets 24
// RULE7 - reverse poisoned completion or write sets 24
// RULE8 - bits 26:25 read 01 forward, 00 reverse
// RULE9 - forward signaled target abort sets 27
// RULE10 - reverse completer abort sent sets 27
// RULE11 - forward received target abort sets 28
// RULE12 - reverse received completer abort sets 28
// RULE13 - forward master abort sets 29
// RULE14 - reverse unsupported request completion sets 29
// RULE15 - forward system error pin sets 30
// RULE16 - reverse fatal/nonfatal message sets 30
// RULE17 - forward any parity error sets 31; the code sets it only on address/data parity error or the perr pin
// RULE18 - reverse poisoned tlp sets 31
// RULE19 - flags reset zero, write-one clear, reserved zero
module bss_secondary_status (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic fwd_rd_data_perr,
    input wire logic fwd_write_phase,
    input wire logic secondary_parity_error_pin_n,
    input wire logic fwd_split_msg_perr,
    input wire logic rev_poisoned_cpl,
    input wire logic rev_poisoned_write,
    input wire logic fwd_target_abort_sent,
    input wire logic rev_ca_cpl_sent,
    input wire logic fwd_target_abort_rcvd,
    input wire logic rev_ca_cpl_rcvd,
    input wire logic fwd_master_abort,
    input wire logic rev_ur_cpl_rcvd,
    input wire logic secondary_system_error_pin_n,
    input wire logic rev_err_msg_rcvd,
    input wire logic fwd_addr_data_perr,
    input wire logic rev_poisoned_tlp
);

    logic [2:0] ctrl_q;
    logic [7:0] evt_q;
    logic [15:0] flags;
    logic flag_mdpe_q;
    logic flag_sta_q;
    logic flag_rta_q;
    logic flag_rma_q;
    logic flag_rse_q;
    logic flag_dpe_q;
    logic [2:0] perr_sync_q;
    logic [2:0] serr_sync_q;
    logic perr_q;
    logic serr_q;
    logic serr_prev_q;
    logic aw_held_q;
    logic w_held_q;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    bss_pkg::bss_bus_state_t wr_state_q;
    bss_pkg::bss_bus_state_t rd_state_q;
    logic [31:0] status_word;
    logic reverse;
    logic perr_en;
    logic do_write;
    logic clear_status;
    logic [15:0] set_bits;
    logic [15:0] clr_bits;

    function automatic logic [31:0] read_word(
        input logic [11:0] addr,
        input logic [31:0] stat,
        input logic [2:0] ctrl,
        input logic [7:0] evt
    );
        logic [31:0] r;
        r = 32'h0000_0000;
        case (addr)
            `BSS_OFF_STATUS: r = stat;
            `BSS_OFF_CTRL: r = {29'h0000_0000, ctrl};
            `BSS_OFF_EVT: r = {24'h00_0000, evt};
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction : read_word

    function automatic logic addr_ok(input logic [11:0] addr);
        return addr == `BSS_OFF_STATUS || addr == `BSS_OFF_CTRL
            || addr == `BSS_OFF_EVT;
    endfunction : addr_ok

    assign reverse = ctrl_q[`BSS_CTRL_REVERSE];
    assign perr_en = ctrl_q[`BSS_CTRL_PERR_EN];

    // pins: three stages, a change counts once stages two and three agree
    always_ff @(posedge aclk) begin
        // idle level after reset, so no false edge follows it
        if (!aresetn) begin
            perr_sync_q <= `BSS_PIN_IDLE;
            serr_sync_q <= `BSS_PIN_IDLE;
        end else begin
            perr_sync_q <= {perr_sync_q[1:0], secondary_parity_error_pin_n};
            serr_sync_q <= {serr_sync_q[1:0], secondary_system_error_pin_n};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            perr_q <= 1'b0;
            serr_q <= 1'b0;
            serr_prev_q <= 1'b0;
        end else begin
            if (perr_sync_q[1] == perr_sync_q[2]) begin
                perr_q <= ~perr_sync_q[2];
            end
            if (serr_sync_q[1] == serr_sync_q[2]) begin
                serr_q <= ~serr_sync_q[2];
            end
            serr_prev_q <= serr_q;
        end
    end

    // read-only bits 23 and 26:25 follow the live mode straps, bit 21 is fixed at one
    always_comb begin
        status_word = {flags, 16'h0000}; // [RULE19]
        status_word[`BSS_BIT_66MHZ] = 1'b1; // [RULE1]
        status_word[`BSS_BIT_FBB] = !reverse
            && !ctrl_q[`BSS_CTRL_PCIX]; // [RULE2] [RULE3]
        status_word[`BSS_LSB_SELT +: 2] = reverse ? `BSS_SELT_REV
            : `BSS_SELT_FWD; // [RULE8]
    end

    always_comb begin
        set_bits = 16'h0000;
        if (!reverse) begin
            set_bits[`BSS_IDX_MDPE] = perr_en && (fwd_rd_data_perr
                || (perr_q && fwd_write_phase)
                || fwd_split_msg_perr); // [RULE4] [RULE5] [RULE6]
            set_bits[`BSS_IDX_STA] = fwd_target_abort_sent; // [RULE9]
            set_bits[`BSS_IDX_RTA] = fwd_target_abort_rcvd; // [RULE11]
            set_bits[`BSS_IDX_RMA] = fwd_master_abort; // [RULE13]
            // edge only, so a long assertion counts once
            set_bits[`BSS_IDX_RSE] = serr_q && !serr_prev_q; // [RULE15]
            // parity enable deliberately not consulted here
            set_bits[`BSS_IDX_DPE] = fwd_addr_data_perr
                || perr_q; // [RULE17]
        end else begin
            set_bits[`BSS_IDX_MDPE] = perr_en
                && (rev_poisoned_cpl || rev_poisoned_write); // [RULE7]
            set_bits[`BSS_IDX_STA] = rev_ca_cpl_sent; // [RULE10]
            set_bits[`BSS_IDX_RTA] = rev_ca_cpl_rcvd; // [RULE12]
            set_bits[`BSS_IDX_RMA] = rev_ur_cpl_rcvd; // [RULE14]
            set_bits[`BSS_IDX_RSE] = rev_err_msg_rcvd; // [RULE16]
            set_bits[`BSS_IDX_DPE] = rev_poisoned_tlp; // [RULE18]
        end
    end

    // write channel: address and data taken in either order
    assign s_axi_awready = !aw_held_q && wr_state_q == bss_pkg::BSS_IDLE;
    assign s_axi_wready = !w_held_q && wr_state_q == bss_pkg::BSS_IDLE;
    assign do_write = wr_state_q == bss_pkg::BSS_IDLE
        && (aw_held_q || s_axi_awvalid) && (w_held_q || s_axi_wvalid);
    assign s_axi_bvalid = wr_state_q == bss_pkg::BSS_RESP;
    assign s_axi_arready = rd_state_q == bss_pkg::BSS_IDLE;
    assign s_axi_rvalid = rd_state_q == bss_pkg::BSS_RESP;

    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    assign wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
    assign wr_data = w_held_q ? wdata_q : s_axi_wdata;
    assign wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
    assign clear_status = do_write && wr_addr == `BSS_OFF_STATUS;
    always_comb begin
        clr_bits = 16'h0000;
        if (clear_status) begin
            if (wr_strb[3]) begin
                clr_bits[15:8] = wr_data[31:24];
            end
            if (wr_strb[2]) begin
                clr_bits[7:0] = wr_data[23:16];
            end
        end
        // only event bits are clearable
        clr_bits = clr_bits & `BSS_W1C_MASK;
    end

    // reserved positions of the status half stay zero
    always_comb begin
        flags = 16'h0000; // [RULE19]
        flags[`BSS_IDX_MDPE] = flag_mdpe_q;
        flags[`BSS_IDX_STA] = flag_sta_q;
        flags[`BSS_IDX_RTA] = flag_rta_q;
        flags[`BSS_IDX_RMA] = flag_rma_q;
        flags[`BSS_IDX_RSE] = flag_rse_q;
        flags[`BSS_IDX_DPE] = flag_dpe_q;
    end

    // set wins over a clear in the same cycle
    // parity error seen while acting as bus master
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_mdpe_q <= 1'b0; // [RULE19]
        end else if (set_bits[`BSS_IDX_MDPE]) begin
            flag_mdpe_q <= 1'b1;
        end else if (clr_bits[`BSS_IDX_MDPE]) begin
            flag_mdpe_q <= 1'b0; // [RULE19]
        end
    end

    // abort signalled by this bridge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_sta_q <= 1'b0; // [RULE19]
        end else if (set_bits[`BSS_IDX_STA]) begin
            flag_sta_q <= 1'b1;
        end else if (clr_bits[`BSS_IDX_STA]) begin
            flag_sta_q <= 1'b0; // [RULE19]
        end
    end

    // abort received from a target
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_rta_q <= 1'b0; // [RULE19]
        end else if (set_bits[`BSS_IDX_RTA]) begin
            flag_rta_q <= 1'b1;
        end else if (clr_bits[`BSS_IDX_RTA]) begin
            flag_rta_q <= 1'b0; // [RULE19]
        end
    end

    // request that ended unclaimed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_rma_q <= 1'b0; // [RULE19]
        end else if (set_bits[`BSS_IDX_RMA]) begin
            flag_rma_q <= 1'b1;
        end else if (clr_bits[`BSS_IDX_RMA]) begin
            flag_rma_q <= 1'b0; // [RULE19]
        end
    end

    // system error reported from the far side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_rse_q <= 1'b0; // [RULE19]
        end else if (set_bits[`BSS_IDX_RSE]) begin
            flag_rse_q <= 1'b1;
        end else if (clr_bits[`BSS_IDX_RSE]) begin
            flag_rse_q <= 1'b0; // [RULE19]
        end
    end

    // address/data parity error, perr pin or poisoned tlp observed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_dpe_q <= 1'b0; // [RULE19]
        end else if (set_bits[`BSS_IDX_DPE]) begin
            flag_dpe_q <= 1'b1;
        end else if (clr_bits[`BSS_IDX_DPE]) begin
            flag_dpe_q <= 1'b0; // [RULE19]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (do_write) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_q <= bss_pkg::BSS_IDLE;
            s_axi_bresp <= `BSS_RESP_OKAY;
        end else begin
            case (wr_state_q)
                bss_pkg::BSS_IDLE: begin
                    if (do_write) begin
                        wr_state_q <= bss_pkg::BSS_RESP;
                        s_axi_bresp <= addr_ok(wr_addr) ? `BSS_RESP_OKAY
                            : `BSS_RESP_SLVERR;
                    end
                end
                bss_pkg::BSS_RESP: begin
                    if (s_axi_bready) begin
                        wr_state_q <= bss_pkg::BSS_IDLE;
                    end
                end
                default: wr_state_q <= bss_pkg::BSS_IDLE;
            endcase
        end
    end

    // mode straps and spare event stay writable so a bench can steer mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= 3'h0;
            evt_q <= 8'h00;
        end else if (do_write && wr_strb[0]) begin
            if (wr_addr == `BSS_OFF_CTRL) begin
                ctrl_q <= wr_data[2:0];
            end
            if (wr_addr == `BSS_OFF_EVT) begin
                evt_q <= wr_data[7:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_q <= bss_pkg::BSS_IDLE;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `BSS_RESP_OKAY;
        end else begin
            case (rd_state_q)
                bss_pkg::BSS_IDLE: begin
                    if (s_axi_arvalid) begin
                        rd_state_q <= bss_pkg::BSS_RESP;
                        s_axi_rdata <= read_word(s_axi_araddr, status_word,
                            ctrl_q, evt_q);
                        s_axi_rresp <= addr_ok(s_axi_araddr)
                            ? `BSS_RESP_OKAY : `BSS_RESP_SLVERR;
                    end
                end
                bss_pkg::BSS_RESP: begin
                    if (s_axi_rready) begin
                        rd_state_q <= bss_pkg::BSS_IDLE;
                    end
                end
                default: rd_state_q <= bss_pkg::BSS_IDLE;
            endcase
        end
    end

endmodule : bss_secondary_status

/* testbench/bss_status_sva.sv */
// checker for the status slave handshake and the status word
// bound to bss_secondary_status, sees its ports only
`timescale 1ns/1ps
module bss_status_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    logic [11:0] ra_q;
    logic st;
    logic um;
    // address kept from the accepted read, the bus drops it after
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            ra_q <= s_axi_araddr;
        end
    end
    assign st = s_axi_rvalid && ra_q == 12'h01C;
    assign um = !(ra_q inside {12'h01C, 12'h040, 12'h044});
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_read_lat: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    ) else $error("read answer not one cycle later");
    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
    ) else $error("read answer dropped early");
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    ) else $error("write answer dropped early");
    a_busy_block: assert property (
        (s_axi_bvalid |-> !s_axi_awready) and (s_axi_rvalid |-> !s_axi_arready)
    ) else $error("request accepted while answer pending");
    a_const_bits: assert property (
        st |-> s_axi_rdata[22:0] == 23'h200000
    ) else $error("constant status bits wrong");
    a_selt_mode: assert property (
        st |-> !s_axi_rdata[26] && (s_axi_rdata[25] || !s_axi_rdata[23])
    ) else $error("select timing or fast b2b wrong");
    a_unmapped_err: assert property (
        s_axi_rvalid && um |-> s_axi_rresp == 2'h2
    ) else $error("unmapped read not refused");
    a_status_okay: assert property (
        st |-> s_axi_rresp == 2'h0
    ) else $error("status read refused");
    a_reset_idle: assert property (
        $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
    ) else $error("answer pending after reset");
endmodule : bss_status_sva

bind bss_secondary_status bss_status_sva u_sva (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready)
);

/* testbench/bss_secondary_status_bench.sv */
// self-checking bench for the secondary status slave
// drives every port itself; clock 10 MHz
`timescale 1ns/1ps
module bss_secondary_status_bench;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] ev = '0;
    logic fwd_rd_data_perr, fwd_write_phase, fwd_split_msg_perr;
    logic rev_poisoned_cpl, rev_poisoned_write, fwd_target_abort_sent;
    logic rev_ca_cpl_sent, fwd_target_abort_rcvd, rev_ca_cpl_rcvd;
    logic fwd_master_abort, rev_ur_cpl_rcvd, rev_err_msg_rcvd;
    logic fwd_addr_data_perr, rev_poisoned_tlp;
    logic secondary_parity_error_pin_n, secondary_system_error_pin_n;
    int n_errors = 0, n_checks = 0;
    // {ctrl, event index, expected flags 31:24}
    logic [15:0] tbl [22] = '{
        16'h4001, 16'h4101, 16'h4208, 16'h4310,
        16'h4420, 16'h4580, 16'h4D81, 16'h4E40,
        16'h0000, 16'h0580, 16'h5601, 16'h5701,
        16'h5808, 16'h5910, 16'h5A20, 16'h5B40,
        16'h5C80, 16'h1600,
        16'h6208, 16'h0D80, 16'h1000, 16'h1E00};
    assign {fwd_write_phase, rev_poisoned_tlp, rev_err_msg_rcvd,
        rev_ur_cpl_rcvd, rev_ca_cpl_rcvd, rev_ca_cpl_sent,
        rev_poisoned_write, rev_poisoned_cpl, fwd_addr_data_perr,
        fwd_master_abort, fwd_target_abort_rcvd, fwd_target_abort_sent,
        fwd_split_msg_perr, fwd_rd_data_perr} = {ev[15], ev[12:0]};
    assign secondary_parity_error_pin_n = ~ev[13];
    assign secondary_system_error_pin_n = ~ev[14];
    bss_secondary_status dut (.*);
    always #50 aclk = ~aclk;
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask : chk32
    task automatic chk2(input logic [1:0] g, input logic [1:0] e);
        chk32({30'h0, g}, {30'h0, e});
    endtask : chk2
    function automatic logic [31:0] exp_st(input logic [2:0] c,
                                           input logic [7:0] m);
        exp_st = {m, 24'h200000};
        if (!c[0]) begin
            exp_st[25] = 1'b1;
            exp_st[23] = !c[1];
        end
    endfunction : exp_st
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        int i;
        int w;
        w = $urandom_range(2, 0);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= (w == 0);
        for (i = 0; i < 20; i++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            r = s_axi_bresp;
            if (s_axi_bvalid && s_axi_bready) break;
            if (i + 1 >= w) s_axi_bready <= 1'b1;
        end
        s_axi_bready <= 1'b0;
        if (i == 20) begin
            n_errors++;
            stop_test();
        end
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int i;
        int w;
        w = $urandom_range(2, 0);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= (w == 0);
        for (i = 0; i < 20; i++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            d = s_axi_rdata;
            r = s_axi_rresp;
            if (s_axi_rvalid && s_axi_rready) break;
            if (i + 1 >= w) s_axi_rready <= 1'b1;
        end
        s_axi_rready <= 1'b0;
        if (i == 20) begin
            n_errors++;
            stop_test();
        end
    endtask : rd
    // pins are held long enough to pass the input filter
    task automatic ev_go(input logic [3:0] x);
        @(posedge aclk);
        ev[x] <= 1'b1;
        ev[15] <= x == 4'hD;
        repeat (x > 12 ? 8 : 1) @(posedge aclk);
        ev <= '0;
        repeat (6) @(posedge aclk);
    endtask : ev_go
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [15:0] e;
        void'($urandom(30136));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(12'h01C, d, r);
        chk32(d, exp_st(3'h0, 8'h00));
        foreach (tbl[k]) begin
            e = tbl[k];
            wr(12'h040, {29'h0, e[14:12]}, r);
            rd(12'h01C, d, r);
            chk32(d, exp_st(e[14:12], 8'h00));
            ev_go(e[11:8]);
            rd(12'h01C, d, r);
            chk32(d, exp_st(e[14:12], e[7:0]));
            wr(12'h01C, $urandom() & ~{e[7:0], 24'h0}, r);
            chk2(r, 2'h0);
            rd(12'h01C, d, r);
            chk32(d, exp_st(e[14:12], e[7:0]));
            wr(12'h01C, $urandom() | {e[7:0], 24'h0}, r);
            rd(12'h01C, d, r);
            chk32(d, exp_st(e[14:12], 8'h00));
        end
        // a partial strobe leaves the upper flag byte untouched
        wr(12'h040, 32'h0000_0001, r);
        ev_go(4'hC);
        s_axi_wstrb <= 4'h7;
        wr(12'h01C, 32'hFFFF_FFFF, r);
        s_axi_wstrb <= 4'hF;
        rd(12'h01C, d, r);
        chk32(d, exp_st(3'h1, 8'h80));
        // a reset in mid-run drops the flags and the mode straps
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(12'h01C, d, r);
        chk32(d, exp_st(3'h0, 8'h00));
        rd(12'h100, d, r);
        chk2(r, 2'h2);
        wr(12'h100, $urandom(), r);
        chk2(r, 2'h2);
        stop_test();
    end
endmodule : bss_secondary_status_bench
